// File: rtl/fsp_defines.svh
// Constants for the flash status and write-protect block.
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
`define FSP_BIT_BUSY      0
`define FSP_BIT_LATCH     1
`define FSP_BIT_LOCK_LOW  7
`define FSP_BIT_LOCK_HIGH 0
`define FSP_BIT_QUAD      1
`define FSP_BIT_PSUS      2
`define FSP_BIT_COMPL     6
`define FSP_BIT_ESUS      7
`define FSP_MID_WMASK     8'h7b
`define FSP_MID_STICKY    8'h38
`define FSP_HIGH_WMASK    8'h61
`define FSP_LOW_WMASK     8'hfc
`define FSP_LOW_RESET     8'h00
`define FSP_MID_RESET     8'h00
`define FSP_HIGH_RESET    8'h40
`define FSP_OP_NONE       3'h0
`define FSP_OP_SRW        3'h1
`define FSP_OP_PROG       3'h2
`define FSP_OP_SECT       3'h3
`define FSP_OP_BLOCK      3'h4
`define FSP_OP_CHIP       3'h5
`define FSP_OP_WEN        3'h6
`define FSP_OP_WDIS       3'h7
`define FSP_ADDR_TOP      23'h7fffff
`define FSP_SEC_SHIFT     12
`define FSP_BLK_SHIFT     16
`endif

// File: rtl/fsp_pkg.sv
// Types shared by the flash status and write-protect block.
package fsp_pkg;
  typedef struct packed {
    logic [2:0]  op;
    logic [22:0] addr;
    logic [7:0]  low;
    logic [7:0]  mid;
    logic [7:0]  high;
    logic [1:0]  which;
  } fsp_cmd_s;
  typedef enum logic [2:0] {
    FSP_IDLE = 3'b001,
    FSP_BUSY = 3'b010,
    FSP_DONE = 3'b100
  } fsp_state_e;
endpackage

// File: rtl/fsp_status_protect.sv
// Status registers and write-protection checks of a serial NOR flash.
//
// Function
// - Complement set inverts mapping: 000 protects all, 111 protects nothing.
// - First byte: busy, latch, five protect bits, low lock bit.
// - Second byte: high lock, quad, suspends, secure locks, complement.
// - Busy reads one while program, erase or status write runs.
// - Latch clear refuses status write, program and erase.
// - Protect bits change only by status write, not when hardware locked.
// - Program, sector and block erase inside protected region are rejected.
// - Chip erase only with code 000 and complement clear, or 111 and set.
// - Lock bits 00: status writable whenever latch set.
// - Lock bits 01: low protect pin blocks status writes.
// - Lock bits 10: status writes blocked until power cycle.
// - Lock bits 11: status writes blocked as with 10, until reset.
// - Power cycle returns lock code 10 to 00.
// - Latch clears at reset, disable, and completion of writes.
// - Quad enable clear keeps pins as protect and hold.
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_status_protect (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             cmd_valid,
  input  wire fsp_pkg::fsp_cmd_s cmd,
  input  wire logic             op_done,
  input  wire logic             protect_pin_n,
  input  wire logic             erase_sus_set,
  input  wire logic             prog_sus_set,
  input  wire logic             sus_clear,
  output logic [7:0]            status_byte_low,
  output logic [7:0]            status_byte_mid,
  output logic [7:0]            status_byte_high,
  output logic                  op_start,
  output logic                  op_reject,
  output logic                  pins_are_protect_hold
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0]          low_ff, nxt_low, mid_ff, nxt_mid, high_ff, nxt_high;
  fsp_pkg::fsp_state_e st_ff, nxt_st;
  logic                start_ff, nxt_start, rej_ff, nxt_rej, qpin_ff, nxt_qpin;
  logic                pin_s1_ff, pin_s2_ff;
  logic                sr_lock, in_prot, allowed, chip_ok;

  // The protect pin is asynchronous, so two flops come before any reader.
  always_ff @(posedge core_clk) begin
    pin_s1_ff <= protect_pin_n;
    pin_s2_ff <= pin_s1_ff;
  end

  // True when an address lies in the region selected by code and complement.
  function automatic logic prot_hit(input logic [4:0] bp, input logic cmpl,
                                    input logic [22:0] a);
    logic [22:0] span;
    logic        in_part;
    span = 23'h0;
    in_part = 1'b0;
    if (bp[2:0] == 3'h0) begin
      in_part = 1'b0;
    end else if (bp[2:0] == 3'h7) begin
      in_part = 1'b1;
    end else if (!bp[4]) begin
      // Fractions 1/64 .. 1/2 of the array, 128 KB to 4 MB.
      span = 23'(23'h20000 << (bp[2:0] - 3'h1));
      in_part = bp[3] ? (a < span) : (a > (`FSP_ADDR_TOP - span));
    end else begin
      // Small windows of 4 KB to 32 KB; codes 1x0 and 101 both give 32 KB.
      span = (bp[2] ? 23'h8000 : 23'(23'h1000 << (bp[1:0] - 2'h1)));
      in_part = bp[3] ? (a < span) : (a > (`FSP_ADDR_TOP - span));
    end
    prot_hit = cmpl ? !in_part : in_part;
  endfunction

  // Status-register write lock from the two lock bits and the pin.
  always_comb begin
    case ({mid_ff[`FSP_BIT_LOCK_HIGH], low_ff[`FSP_BIT_LOCK_LOW]})
      2'b00:   sr_lock = 1'b0;
      2'b01:   sr_lock = !pin_s2_ff;
      2'b10:   sr_lock = 1'b1;
      default: sr_lock = 1'b1;
    endcase
  end

  // Erases check the first byte of the sector or block they clear.
  always_comb begin
    logic [22:0] base;
    base = cmd.addr;
    if (cmd.op == `FSP_OP_SECT) begin
      base = {cmd.addr[22:`FSP_SEC_SHIFT], 12'h000};
    end else if (cmd.op == `FSP_OP_BLOCK) begin
      base = {cmd.addr[22:`FSP_BLK_SHIFT], 16'h0000};
    end
    in_prot = prot_hit(low_ff[6:2], mid_ff[`FSP_BIT_COMPL], base);
    chip_ok = (low_ff[4:2] == 3'h0 && !mid_ff[`FSP_BIT_COMPL]) ||
              (low_ff[4:2] == 3'h7 && mid_ff[`FSP_BIT_COMPL]);
  end

  // Acceptance of a command; one request at a time, ignored while busy.
  always_comb begin
    allowed = 1'b0;
    case (cmd.op)
      `FSP_OP_SRW:   allowed = low_ff[`FSP_BIT_LATCH] && !sr_lock;
      `FSP_OP_PROG,
      `FSP_OP_SECT,
      `FSP_OP_BLOCK: allowed = low_ff[`FSP_BIT_LATCH] && !in_prot;
      `FSP_OP_CHIP:  allowed = low_ff[`FSP_BIT_LATCH] && chip_ok;
      default:       allowed = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state of the registers and the busy sequencer.
  always_comb begin
    nxt_low   = low_ff;
    nxt_mid   = mid_ff;
    nxt_high  = high_ff;
    nxt_st    = st_ff;
    nxt_start = 1'b0;
    nxt_rej   = 1'b0;
    nxt_qpin  = !mid_ff[`FSP_BIT_QUAD];
    case (st_ff)
      fsp_pkg::FSP_IDLE: begin
        if (cmd_valid) begin
          if (cmd.op == `FSP_OP_WEN) begin
            nxt_low[`FSP_BIT_LATCH] = 1'b1;
          end else if (cmd.op == `FSP_OP_WDIS) begin
            nxt_low[`FSP_BIT_LATCH] = 1'b0;
          end else if (cmd.op != `FSP_OP_NONE && allowed) begin
            if (cmd.op == `FSP_OP_SRW) begin
              // Only the written byte changes; busy and latch stay hardware.
              if (cmd.which == 2'h0) begin
                nxt_low = (low_ff & ~`FSP_LOW_WMASK) | (cmd.low & `FSP_LOW_WMASK);
              end else if (cmd.which == 2'h1) begin
                // Secure lock bits may be set but never cleared.
                nxt_mid = (mid_ff & ~`FSP_MID_WMASK) | (cmd.mid & `FSP_MID_WMASK)
                          | (mid_ff & `FSP_MID_STICKY);
              end else begin
                nxt_high = cmd.high & `FSP_HIGH_WMASK;
              end
            end
            nxt_low[`FSP_BIT_BUSY] = 1'b1;
            nxt_start = 1'b1;
            nxt_st    = fsp_pkg::FSP_BUSY;
          end else if (cmd.op != `FSP_OP_NONE) begin
            nxt_rej = 1'b1;
          end
        end
      end
      fsp_pkg::FSP_BUSY: begin
        if (op_done) begin
          nxt_st = fsp_pkg::FSP_DONE;
        end
      end
      fsp_pkg::FSP_DONE: begin
        nxt_low[`FSP_BIT_BUSY] = 1'b0;
        nxt_low[`FSP_BIT_LATCH] = 1'b0;
        nxt_st = fsp_pkg::FSP_IDLE;
      end
      default: nxt_st = fsp_pkg::FSP_IDLE;
    endcase
    // Suspend flags: a set in the clearing cycle wins.
    if (sus_clear) begin
      nxt_mid[`FSP_BIT_ESUS] = 1'b0;
      nxt_mid[`FSP_BIT_PSUS] = 1'b0;
    end
    if (erase_sus_set) nxt_mid[`FSP_BIT_ESUS] = 1'b1;
    if (prog_sus_set)  nxt_mid[`FSP_BIT_PSUS] = 1'b1;
  end

  // Reset models the power cycle; lock code 10 falls back to 00 there.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      low_ff   <= `FSP_LOW_RESET;
      mid_ff   <= `FSP_MID_RESET;
      high_ff  <= `FSP_HIGH_RESET;
      st_ff    <= fsp_pkg::FSP_IDLE;
      start_ff <= 1'b0;
      rej_ff   <= 1'b0;
      qpin_ff  <= 1'b1;
    end else begin
      low_ff   <= nxt_low;
      mid_ff   <= nxt_mid;
      high_ff  <= nxt_high;
      st_ff    <= nxt_st;
      start_ff <= nxt_start;
      rej_ff   <= nxt_rej;
      qpin_ff  <= nxt_qpin;
    end
  end

  assign status_byte_low       = low_ff;
  assign status_byte_mid       = mid_ff;
  assign status_byte_high      = high_ff;
  assign op_start              = start_ff;
  assign op_reject             = rej_ff;
  assign pins_are_protect_hold = qpin_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the protection behaviour.
  busy_follows_start_a: assert property (@(posedge core_clk) disable iff (reset)
    op_start |-> status_byte_low[`FSP_BIT_BUSY]) else $error("busy not set");
  latch_gates_start_a: assert property (@(posedge core_clk) disable iff (reset)
    op_start |-> $past(low_ff[`FSP_BIT_LATCH])) else $error("start without latch");
  hw_lock_blocks_a: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid && cmd.op == `FSP_OP_SRW && low_ff[`FSP_BIT_LOCK_LOW] && !pin_s2_ff
     && st_ff == fsp_pkg::FSP_IDLE) |=> !op_start) else $error("locked write ran");
  chip_check_a: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid && cmd.op == `FSP_OP_CHIP && !chip_ok && st_ff == fsp_pkg::FSP_IDLE)
    |=> op_reject) else $error("chip erase not refused");
  prot_region_a: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid && cmd.op == `FSP_OP_PROG && in_prot && st_ff == fsp_pkg::FSP_IDLE)
    |=> !op_start) else $error("protected program ran");
  latch_clear_end_a: assert property (@(posedge core_clk) disable iff (reset)
    (st_ff == fsp_pkg::FSP_DONE) |=> !low_ff[`FSP_BIT_LATCH] && !low_ff[`FSP_BIT_BUSY])
    else $error("latch or busy left set");
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    (status_byte_high & ~`FSP_HIGH_WMASK) == 8'h00) else $error("reserved set");
  compl_all_a: assert property (@(posedge core_clk) disable iff (reset)
    (mid_ff[`FSP_BIT_COMPL] && low_ff[4:2] == 3'h0) |-> in_prot)
    else $error("complement zero code unprotected");
  full_lock_a: assert property (@(posedge core_clk) disable iff (reset)
    (cmd_valid && cmd.op == `FSP_OP_SRW && mid_ff[`FSP_BIT_LOCK_HIGH]) |=> !op_start)
    else $error("locked status written");
  start_cover: cover property (@(posedge core_clk) op_start);
  reject_cover: cover property (@(posedge core_clk) op_reject);
  srw_cover: cover property (@(posedge core_clk)
    op_start && $past(cmd.op) == `FSP_OP_SRW);
endmodule

// File: tb/fsp_engine_model.sv
// Far-side engine model that finishes each started operation.
`timescale 1ns/1ps
module fsp_engine_model (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       op_start,
  input  wire logic [3:0] delay,
  output logic            op_done
);
  logic [3:0] cnt_ff;
  logic       run_ff;
  // Done comes only after a start, after a delay from prompt to slow.
  always_ff @(posedge core_clk) begin
    op_done <= 1'b0;
    if (reset) begin
      run_ff <= 1'b0;
      cnt_ff <= 4'h0;
    end else if (op_start) begin
      run_ff <= 1'b1;
      cnt_ff <= delay;
    end else if (run_ff && cnt_ff == 4'h0) begin
      run_ff  <= 1'b0;
      op_done <= 1'b1;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule

// File: tb/fsp_status_protect_bench.sv
// Self-checking bench for the flash status and write-protect block.
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_status_protect_bench;
  localparam logic [2:0] SR = `FSP_OP_SRW, PG = `FSP_OP_PROG, SC = `FSP_OP_SECT;
  localparam logic [2:0] BK = `FSP_OP_BLOCK, CE = `FSP_OP_CHIP, WE = `FSP_OP_WEN;
  logic              core_clk = 1'b0;
  logic              reset = 1'b1;
  logic              cmd_valid = 1'b0;
  fsp_pkg::fsp_cmd_s cmd = '0;
  logic              op_done;
  logic              pin_n = 1'b1;
  logic              esus = 1'b0;
  logic              psus = 1'b0;
  logic              sclr = 1'b0;
  logic [7:0]        lo, md, hi;
  logic              op_start, op_reject, pins;
  logic [3:0]        delay = 4'h0;
  logic [31:0]       lfsr = 32'hdedf;
  logic [1:0]        exp_q[$];
  logic [1:0]        e;
  int                miscompares = 0;
  int                num_checks = 0;
  always #50 core_clk = ~core_clk;
  fsp_status_protect dut (.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd(cmd), .op_done(op_done), .protect_pin_n(pin_n), .erase_sus_set(esus),
    .prog_sus_set(psus), .sus_clear(sclr), .status_byte_low(lo), .status_byte_mid(md),
    .status_byte_high(hi), .op_start(op_start), .op_reject(op_reject),
    .pins_are_protect_hold(pins));
  fsp_engine_model engine (.core_clk(core_clk), .reset(reset), .op_start(op_start),
    .delay(delay), .op_done(op_done));
  ////////////////////////////////////////////////////////////////////////////////
  // Pseudo-random source; feeds addresses and engine delays.
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    if (exp_q.size() != 0) miscompares++;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Compares one byte and counts the result.
  task automatic chk(input logic [7:0] got, input logic [7:0] ex);
    num_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask
  // Sends one command, notes the answer expected (10 start, 01 refuse) and waits for idle.
  task automatic run(input logic [2:0] op, input logic [22:0] a, input logic [1:0] w,
                     input logic [7:0] d, input logic [1:0] ex);
    int n;
    @(posedge core_clk);
    lfsr = nxt(lfsr);
    delay <= lfsr[3:0];
    cmd_valid <= 1'b1;
    cmd <= '{op: op, addr: a, low: d, mid: d, high: d, which: w};
    if (ex != 2'b00) exp_q.push_back(ex);
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    repeat (3) @(negedge core_clk);
    if (ex == 2'b10) chk({7'h00, lo[0]}, 8'h01);
    for (n = 0; n < 40 && lo[0] !== 1'b0; n++) @(negedge core_clk);
    if (n == 40) begin
      miscompares++;
      close_out();
    end
  endtask
  // Sets the latch, checks it, then sends the command.
  task automatic arm(input logic [2:0] op, input logic [22:0] a, input logic [1:0] w,
                     input logic [7:0] d, input logic [1:0] ex);
    run(WE, 23'h0, 2'h0, 8'h00, 2'b00);
    chk({7'h00, lo[1]}, 8'h01);
    run(op, a, w, d, ex);
  endtask
  // Drives the protect pin, then lets the synchroniser settle.
  task automatic pin(input logic v);
    @(posedge core_clk);
    pin_n <= v;
    repeat (8) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Every start or refuse pulse is matched against the oldest note.
  always @(posedge core_clk) begin
    if (op_start === 1'b1 || op_reject === 1'b1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 2'b00;
      num_checks++;
      if ({op_start, op_reject} !== e) begin
        miscompares++;
        $display("BAD t=%0t got=%h exp=%h", $time, {op_start, op_reject}, e);
      end
    end
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk(lo, 8'h00);
    chk(md, 8'h00);
    chk(hi, 8'h40);
    chk({7'h00, pins}, 8'h01);
    run(SR, 23'h0, 2'h0, 8'h1c, 2'b01);
    run(WE, 23'h0, 2'h0, 8'h00, 2'b00);
    run(`FSP_OP_WDIS, 23'h0, 2'h0, 8'h00, 2'b00);
    run(PG, 23'h1000, 2'h0, 8'h00, 2'b01);
    arm(SR, 23'h0, 2'h2, 8'hff, 2'b10);
    chk(hi, 8'h61);
    arm(SR, 23'h0, 2'h1, 8'h4a, 2'b10);
    chk(md, 8'h4a);
    chk({lo[1], 6'h00, pins}, 8'h00);
    arm(SR, 23'h0, 2'h1, 8'h40, 2'b10);
    chk(md, 8'h48);
    arm(PG, 23'h7fffff, 2'h0, 8'h00, 2'b01);
    arm(CE, 23'h0, 2'h0, 8'h00, 2'b01);
    arm(SR, 23'h0, 2'h0, 8'h1c, 2'b10);
    arm(PG, lfsr[22:0], 2'h0, 8'h00, 2'b10);
    arm(CE, 23'h0, 2'h0, 8'h00, 2'b10);
    arm(SR, 23'h0, 2'h0, 8'h70, 2'b10);
    arm(SC, 23'h007000, 2'h0, 8'h00, 2'b10);
    arm(SC, 23'h008000, 2'h0, 8'h00, 2'b01);
    arm(BK, 23'h010000, 2'h0, 8'h00, 2'b01);
    arm(PG, 23'h007fff, 2'h0, 8'h00, 2'b10);
    arm(CE, 23'h0, 2'h0, 8'h00, 2'b01);
    arm(SR, 23'h0, 2'h0, 8'hf0, 2'b10);
    pin(1'b0);
    arm(SR, 23'h0, 2'h0, 8'h00, 2'b01);
    chk(lo & 8'hfc, 8'hf0);
    pin(1'b1);
    arm(SR, 23'h0, 2'h0, 8'h70, 2'b10);
    arm(SR, 23'h0, 2'h1, 8'h41, 2'b10);
    arm(SR, 23'h0, 2'h0, 8'h00, 2'b01);
    arm(SR, 23'h0, 2'h1, 8'h40, 2'b01);
    @(posedge core_clk);
    esus <= 1'b1;
    psus <= 1'b1;
    @(posedge core_clk);
    esus <= 1'b0;
    psus <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk(md & 8'h84, 8'h84);
    @(posedge core_clk);
    sclr <= 1'b1;
    @(posedge core_clk);
    sclr <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk(md & 8'h84, 8'h00);
    // A set that meets a clear in the same cycle must win.
    @(posedge core_clk);
    esus <= 1'b1;
    sclr <= 1'b1;
    @(posedge core_clk);
    esus <= 1'b0;
    sclr <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk(md & 8'h84, 8'h80);
    @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk(md, 8'h00);
    arm(SR, 23'h0, 2'h0, 8'h1c, 2'b10);
    // Lock code 11 is reached through code 01 with the pin high.
    arm(SR, 23'h0, 2'h0, 8'h9c, 2'b10);
    arm(SR, 23'h0, 2'h1, 8'h01, 2'b10);
    arm(SR, 23'h0, 2'h0, 8'h1c, 2'b01);
    chk(md & 8'h01, 8'h01);
    close_out();
  end
endmodule
